/* File: core/ebp_cfg.svh */
// constants for the external bus select and strobe port
// assumes one system clock; included by the package and the top module
`ifndef EBP_CFG_SVH
`define EBP_CFG_SVH
`define EBP_ADDR_W 32
`define EBP_DATA_W 64
`define EBP_NUM_BANKS 4
`define EBP_SIZE_W 4
`define EBP_EXT_BASE 32'h0010_0000
`define EBP_BANK_SHIFT_MIN 6'h0c
`define EBP_STB_RDL 0
`define EBP_STB_RDH 1
`define EBP_STB_WRL 2
`define EBP_STB_WRH 3
`define EBP_STB_IDLE 4'hf
`define EBP_SEL_NONE 4'hf
`define EBP_WORD_LO 0
`define EBP_WORD_HI 1
`endif

/* File: core/ebp_pkg.sv */
// types for the external bus select and strobe port
// assumes ebp_cfg.svh is on the include path
package ebp_pkg;
`include "ebp_cfg.svh"

  // one-hot access sequencer states
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_access = 3'b010,
    st_end = 3'b100
  } ebp_state_type;

  // all state of the top module
  typedef struct packed {
    ebp_state_type state;
    logic [`EBP_ADDR_W-1:0] addr_out;
    logic addr_oe_n;
    logic [`EBP_DATA_W-1:0] data_out;
    logic data_oe_n;
    logic [`EBP_NUM_BANKS-1:0] bank_sel_n;
    logic sel_oe_n;
    logic [3:0] strobe_n;
    logic strobe_oe_n;
    logic req_we;
    logic [1:0] req_words;
    logic sync_mode;
    logic core_done;
    logic [`EBP_DATA_W-1:0] core_rdata;
    logic [3:0] slv_prev_n;
    logic [3:0] slv_event;
    logic [`EBP_ADDR_W-1:0] slv_addr;
    logic [`EBP_DATA_W-1:0] slv_wdata;
  } ebp_regs_type;
endpackage : ebp_pkg

/* File: core/ebp_sync2.sv */
// two-flop synchroniser for a bundle of pin inputs
// assumes the pins are asynchronous to clk_sys; reset is synchronous
`timescale 1ns/1ns
module ebp_sync2
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins in, stable copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ebp_sync_type;

  ebp_sync_type r;
  ebp_sync_type next_r;

  // meta stage feeds only the stable stage
  always_comb
  begin
    next_r.meta = d;
    next_r.stable = r.meta;
    if (rst)
    begin
      next_r.meta = RST_VAL;
      next_r.stable = RST_VAL;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    r <= next_r;
  end

  assign q = r.stable;
endmodule : ebp_sync2

/* File: core/ebp_port.sv */
// external bus port: address, data, bank selects and word strobes
// assumes core requests on clk_sys; bus pins are asynchronous and synced
`timescale 1ns/1ns
`include "ebp_cfg.svh"
module ebp_port
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // core request side
  input wire logic core_req,
  input wire logic core_write,
  input wire logic core_low,
  input wire logic core_high,
  input wire logic core_sync,
  input wire logic [`EBP_ADDR_W-1:0] core_addr,
  input wire logic [`EBP_DATA_W-1:0] core_wdata,
  output logic core_done,
  output logic [`EBP_DATA_W-1:0] core_rdata,
  // ownership and configuration
  input wire logic bus_master,
  input wire logic [`EBP_SIZE_W-1:0] bank_size_sel,
  // inbound slave accesses to internal memory
  input wire logic [`EBP_DATA_W-1:0] slave_rdata,
  output logic [`EBP_ADDR_W-1:0] slave_addr,
  output logic [`EBP_DATA_W-1:0] slave_wdata,
  output logic [3:0] slave_strobe_event,
  // address and data pins
  input wire logic [`EBP_ADDR_W-1:0] ext_address_bus_in,
  output logic [`EBP_ADDR_W-1:0] ext_address_bus_out,
  output logic ext_address_bus_oe_n,
  input wire logic [`EBP_DATA_W-1:0] ext_data_bus_in,
  output logic [`EBP_DATA_W-1:0] ext_data_bus_out,
  output logic ext_data_bus_oe_n,
  // bank select pins
  output logic [`EBP_NUM_BANKS-1:0] bank_select_n,
  output logic bank_select_oe_n,
  // strobe pins
  input wire logic read_low_word_strobe_n_in,
  output logic read_low_word_strobe_n_out,
  output logic read_low_word_strobe_n_oe_n,
  input wire logic read_high_word_strobe_n_in,
  output logic read_high_word_strobe_n_out,
  output logic read_high_word_strobe_n_oe_n,
  input wire logic write_low_word_strobe_n_in,
  output logic write_low_word_strobe_n_out,
  output logic write_low_word_strobe_n_oe_n,
  input wire logic write_high_word_strobe_n_in,
  output logic write_high_word_strobe_n_out,
  output logic write_high_word_strobe_n_oe_n,
  // handshake pins
  input wire logic ack,
  input wire logic suspend_bus_tristate_n
);
  import ebp_pkg::*;

  localparam int SYNC_W = 2 + 4 + `EBP_ADDR_W + `EBP_DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_RST =
    {1'b0, 1'b1, `EBP_STB_IDLE, {`EBP_ADDR_W{1'b0}}, {`EBP_DATA_W{1'b0}}};

  ebp_regs_type r;
  ebp_regs_type next_r;
  logic ack_s;
  logic susp_n_s;
  logic [3:0] sl_n;
  logic [`EBP_ADDR_W-1:0] addr_s;
  logic [`EBP_DATA_W-1:0] data_s;

  // one-hot select for the bank holding addr, zero when outside all banks
  function automatic logic [`EBP_NUM_BANKS-1:0] bank_decode(
    input logic [`EBP_ADDR_W-1:0] addr,
    input logic [`EBP_SIZE_W-1:0] size_sel);
    logic [5:0] sh;
    logic [`EBP_ADDR_W-1:0] idx;
    sh = `EBP_BANK_SHIFT_MIN + {2'h0, size_sel};
    idx = (addr - `EBP_EXT_BASE) >> sh;
    bank_decode = '0;
    if (addr >= `EBP_EXT_BASE && idx < `EBP_NUM_BANKS)
      bank_decode[idx[1:0]] = 1'b1;
  endfunction : bank_decode

  // every pin input crosses two flops before use
  ebp_sync2 #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({ack, suspend_bus_tristate_n, write_high_word_strobe_n_in,
        write_low_word_strobe_n_in, read_high_word_strobe_n_in,
        read_low_word_strobe_n_in, ext_address_bus_in, ext_data_bus_in}),
    .q({ack_s, susp_n_s, sl_n, addr_s, data_s})
  );

  // sequencer, pin drive and slave capture
  always_comb
  begin
    logic master_ok;
    logic busy;
    logic slave_rd;
    logic [`EBP_NUM_BANKS-1:0] sel;
    master_ok = bus_master && susp_n_s;
    busy = 1'b0;
    slave_rd = 1'b0;
    sel = '0;
    next_r = r;
    next_r.core_done = 1'b0;
    next_r.slv_event = 4'h0;
    case (r.state)
      st_idle:
      begin
        if (core_req && master_ok)
        begin
          next_r.state = st_access;
          next_r.addr_out = core_addr;
          next_r.data_out = core_wdata;
          next_r.req_we = core_write;
          next_r.req_words = {core_high, core_low};
          next_r.sync_mode = core_sync;
        end
      end
      st_access:
      begin
        // a suspended or lost bus halts the access rather than ending it
        if (master_ok && ack_s)
        begin
          next_r.state = st_end;
          next_r.core_done = 1'b1;
          if (!r.req_we)
            next_r.core_rdata = data_s;
        end
      end
      st_end:
        next_r.state = st_idle;
      default:
        next_r.state = st_idle;
    endcase

    // bus outputs follow the next state so they leave flops directly
    busy = (next_r.state == st_access);
    sel = bank_decode(next_r.addr_out, bank_size_sel);
    if (next_r.sync_mode)
      next_r.bank_sel_n = busy ? ~sel : `EBP_SEL_NONE;
    else
      next_r.bank_sel_n = (next_r.state != st_idle) ? ~sel : `EBP_SEL_NONE;
    next_r.addr_oe_n = !(master_ok && next_r.state != st_idle);
    next_r.sel_oe_n = next_r.addr_oe_n;
    next_r.strobe_oe_n = !master_ok;
    next_r.strobe_n = `EBP_STB_IDLE;
    if (busy && !next_r.req_we)
    begin
      next_r.strobe_n[`EBP_STB_RDL] = !next_r.req_words[`EBP_WORD_LO];
      next_r.strobe_n[`EBP_STB_RDH] = !next_r.req_words[`EBP_WORD_HI];
    end
    else if (busy)
    begin
      next_r.strobe_n[`EBP_STB_WRL] = !next_r.req_words[`EBP_WORD_LO];
      next_r.strobe_n[`EBP_STB_WRH] = !next_r.req_words[`EBP_WORD_HI];
    end

    // slave side: a falling strobe marks one inbound word access
    slave_rd = !bus_master && susp_n_s &&
               (!sl_n[`EBP_STB_RDL] || !sl_n[`EBP_STB_RDH]);
    if (!bus_master)
    begin
      for (int i = 0; i < 4; i++)
        next_r.slv_event[i] = r.slv_prev_n[i] && !sl_n[i];
      if (|(r.slv_prev_n & ~sl_n))
      begin
        next_r.slv_addr = addr_s;
        next_r.slv_wdata = data_s;
      end
      if (slave_rd)
        next_r.data_out = slave_rdata;
    end
    next_r.slv_prev_n = sl_n;
    // data is the one bus a slave still drives, and only on inbound reads
    next_r.data_oe_n = !((master_ok && busy && next_r.req_we) || slave_rd);

    if (rst)
    begin
      next_r = '0;
      next_r.state = st_idle;
      next_r.addr_oe_n = 1'b1;
      next_r.data_oe_n = 1'b1;
      next_r.sel_oe_n = 1'b1;
      next_r.strobe_oe_n = 1'b1;
      next_r.bank_sel_n = `EBP_SEL_NONE;
      next_r.strobe_n = `EBP_STB_IDLE;
      next_r.slv_prev_n = `EBP_STB_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    r <= next_r;
  end

  // ports straight from the state flops
  assign core_done = r.core_done;
  assign core_rdata = r.core_rdata;
  assign slave_addr = r.slv_addr;
  assign slave_wdata = r.slv_wdata;
  assign slave_strobe_event = r.slv_event;
  assign ext_address_bus_out = r.addr_out;
  assign ext_address_bus_oe_n = r.addr_oe_n;
  assign ext_data_bus_out = r.data_out;
  assign ext_data_bus_oe_n = r.data_oe_n;
  assign bank_select_n = r.bank_sel_n;
  assign bank_select_oe_n = r.sel_oe_n;
  assign read_low_word_strobe_n_out = r.strobe_n[`EBP_STB_RDL];
  assign read_high_word_strobe_n_out = r.strobe_n[`EBP_STB_RDH];
  assign write_low_word_strobe_n_out = r.strobe_n[`EBP_STB_WRL];
  assign write_high_word_strobe_n_out = r.strobe_n[`EBP_STB_WRH];
  assign read_low_word_strobe_n_oe_n = r.strobe_oe_n;
  assign read_high_word_strobe_n_oe_n = r.strobe_oe_n;
  assign write_low_word_strobe_n_oe_n = r.strobe_oe_n;
  assign write_high_word_strobe_n_oe_n = r.strobe_oe_n;

  // checks on the driven bus
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_rd_wr_excl: assert property (
    !((!r.strobe_n[`EBP_STB_RDL] || !r.strobe_n[`EBP_STB_RDH]) &&
      (!r.strobe_n[`EBP_STB_WRL] || !r.strobe_n[`EBP_STB_WRH])))
    else $error("read and write strobes together");
  a_slave_release: assert property (
    !bus_master |=> r.addr_oe_n && r.strobe_oe_n && r.sel_oe_n)
    else $error("slave drives address, select or strobes");
  a_suspend_release: assert property (
    !susp_n_s |=> r.addr_oe_n && r.strobe_oe_n && r.sel_oe_n && r.data_oe_n)
    else $error("bus driven while suspended");
  a_access_addr: assert property (
    (r.state == st_idle && core_req && bus_master && susp_n_s) |=>
    (r.state == st_access && !r.addr_oe_n && r.addr_out == $past(core_addr)))
    else $error("address not driven at access start");
  a_ack_wait: assert property (
    (r.state == st_access && !ack_s) |=> (r.state == st_access && !r.core_done))
    else $error("access ended without ack");
  a_ack_done: assert property (
    (r.state == st_access && ack_s && bus_master && susp_n_s) |=>
    r.core_done ##1 (r.state == st_idle && !r.core_done))
    else $error("ack did not complete access");
  a_sync_sel_drop: assert property (
    (r.sync_mode && r.state == st_access && ack_s && bus_master && susp_n_s)
    |=> r.bank_sel_n == `EBP_SEL_NONE)
    else $error("sync select held after ack");
  a_sel_decode: assert property (
    r.state == st_access |->
    r.bank_sel_n == ~bank_decode(r.addr_out, bank_size_sel))
    else $error("bank select not address decode");
  a_async_sel: assert property (
    (!r.sync_mode && r.state == st_end) |->
    r.bank_sel_n == ~bank_decode(r.addr_out, bank_size_sel))
    else $error("async select left address early");
  a_read_strobe: assert property (
    (r.state == st_access && !r.req_we) |->
    (r.strobe_n[`EBP_STB_RDL] == !r.req_words[`EBP_WORD_LO] &&
     r.strobe_n[`EBP_STB_RDH] == !r.req_words[`EBP_WORD_HI]))
    else $error("read strobes wrong for words");
  a_write_strobe: assert property (
    (r.state == st_access && r.req_we) |->
    (r.strobe_n[`EBP_STB_WRL] == !r.req_words[`EBP_WORD_LO] &&
     r.strobe_n[`EBP_STB_WRH] == !r.req_words[`EBP_WORD_HI]))
    else $error("write strobes wrong for words");
  a_slave_event: assert property (
    (!bus_master && r.slv_prev_n[`EBP_STB_WRL] && !sl_n[`EBP_STB_WRL]) |=>
    (r.slv_event[`EBP_STB_WRL] && r.slv_addr == $past(addr_s)))
    else $error("inbound write not reported");

  c_read_done: cover property (r.state == st_access && !r.req_we ##1 r.core_done);
  c_write_done: cover property (r.state == st_access && r.req_we ##1 r.core_done);
  c_wait_state: cover property (r.state == st_access && !ack_s [*3] ##1 ack_s);
  c_slave_read: cover property (!r.data_oe_n && !bus_master);
endmodule : ebp_port

/* File: sim/ebp_ext_mem.sv */
// partner model: external memory answering strobes, waits through ack
// assumes device pins on clk_sys; the device syncs ack and data 2 flops
`timescale 1ns/1ns
module ebp_ext_mem
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // device bus pins
  input wire logic [31:0] addr,
  input wire logic addr_oe_n,
  input wire logic [63:0] wdata,
  input wire logic [3:0] strobe_n,
  input wire logic strobe_oe_n,
  // wait states asked by the bench
  input wire logic [7:0] wait_n,
  // answer pins
  output logic [63:0] rdata,
  output logic ack
);
  logic [63:0] mem [16];
  logic [63:0] last;
  logic [7:0] cnt;
  logic [3:0] key;
  assign key = {addr[13:12], addr[1:0]};
  // ack low from address start: covers the data sync, never early
  assign ack = (cnt >= wait_n + 8'h03);
  // data only while a read strobe is low, else a toggling pattern
  assign rdata = (!strobe_oe_n && !(&strobe_n[1:0])) ? mem[key] : ~last;
  // wait counter, write halves on their own strobes
  always_ff @(posedge clk_sys)
  begin
    last <= rst ? 64'h0 : rdata;
    cnt <= (rst || addr_oe_n) ? 8'h00 : cnt + 8'h01;
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 64'h0;
    end
    else if (!strobe_oe_n)
    begin
      if (!strobe_n[2])
        mem[key][31:0] <= wdata[31:0];
      if (!strobe_n[3])
        mem[key][63:32] <= wdata[63:32];
    end
  end
endmodule : ebp_ext_mem

/* File: sim/tb_external_bus_select_strobe_port.sv */
// testbench for the external bus port, master and slave sides
// assumes bank size select changes only while the port is idle
`timescale 1ns/1ns
`include "ebp_cfg.svh"
module tb_external_bus_select_strobe_port;
  logic clk_sys, rst, core_req, core_write, core_low, core_high, core_sync;
  logic bus_master, suspend_n, core_done, ack;
  logic addr_oe_n, data_oe_n, sel_oe_n, stb_oe_n;
  logic [31:0] core_addr, slv_addr, addr_out, slave_addr;
  logic [63:0] core_wdata, core_rdata, slave_rdata, slave_wdata, data_out;
  logic [63:0] mdl_data, slv_data, data_in;
  logic [3:0] bank_sel_n, stb_out, stb_in, tb_stb, slave_ev;
  logic [7:0] wt;
  logic [3:0] bsz;
  logic [2:0] stb_oe_x;
  logic [63:0] shadow [16];
  int errors, n_checks, cycles, seed;
  // strobe wires: device drives when enabled, bench otherwise
  assign stb_in = stb_oe_n ? tb_stb : stb_out;
  assign data_in = bus_master ? mdl_data : slv_data;
  ebp_port uut (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
    .core_write(core_write), .core_low(core_low), .core_high(core_high),
    .core_sync(core_sync), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_done(core_done), .core_rdata(core_rdata),
    .bus_master(bus_master), .bank_size_sel(bsz),
    .slave_rdata(slave_rdata), .slave_addr(slave_addr),
    .slave_wdata(slave_wdata), .slave_strobe_event(slave_ev),
    .ext_address_bus_in(slv_addr), .ext_address_bus_out(addr_out),
    .ext_address_bus_oe_n(addr_oe_n), .ext_data_bus_in(data_in),
    .ext_data_bus_out(data_out), .ext_data_bus_oe_n(data_oe_n),
    .bank_select_n(bank_sel_n), .bank_select_oe_n(sel_oe_n),
    .read_low_word_strobe_n_in(stb_in[0]),
    .read_low_word_strobe_n_out(stb_out[0]),
    .read_low_word_strobe_n_oe_n(stb_oe_n),
    .read_high_word_strobe_n_in(stb_in[1]),
    .read_high_word_strobe_n_out(stb_out[1]),
    .read_high_word_strobe_n_oe_n(stb_oe_x[0]),
    .write_low_word_strobe_n_in(stb_in[2]),
    .write_low_word_strobe_n_out(stb_out[2]),
    .write_low_word_strobe_n_oe_n(stb_oe_x[1]),
    .write_high_word_strobe_n_in(stb_in[3]),
    .write_high_word_strobe_n_out(stb_out[3]),
    .write_high_word_strobe_n_oe_n(stb_oe_x[2]),
    .ack(ack), .suspend_bus_tristate_n(suspend_n));
  ebp_ext_mem mdl (.clk_sys(clk_sys), .rst(rst), .addr(addr_out),
    .addr_oe_n(addr_oe_n), .wdata(data_out), .strobe_n(stb_out),
    .strobe_oe_n(stb_oe_n), .wait_n(wt), .rdata(mdl_data), .ack(ack));
  // free-running clock, 20 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, well above the run length
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end
  // bank a select should decode; outside the four banks none
  function automatic logic [3:0] exp_sel(input logic [31:0] a);
    logic [31:0] b;
    b = (a - `EBP_EXT_BASE) >> (`EBP_BANK_SHIFT_MIN + bsz);
    if (a < `EBP_EXT_BASE || b > 32'h3)
      return 4'hf;
    return ~(4'h1 << b[1:0]);
  endfunction : exp_sel
  task automatic chk(input string nm, input logic [63:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one master access, request held until done
  task automatic access(input logic we, lo, hi, sy, input logic [31:0] a,
    input logic [63:0] wd);
    logic [3:0] es;
    int n;
    logic [63:0] m;
    logic [3:0] key;
    es = ~{hi & we, lo & we, hi & ~we, lo & ~we};
    // only the halves that were strobed are checked against memory data
    m = {{32{hi}}, {32{lo}}};
    key = {a[13:12], a[1:0]};
    @(negedge clk_sys);
    {core_write, core_low, core_high, core_sync} = {we, lo, hi, sy};
    core_addr = a;
    core_wdata = wd;
    wt = 8'($random(seed) & 7);
    core_req = 1'b1;
    n = 0;
    while (core_done !== 1'b1 && n < 60)
    begin
      @(negedge clk_sys);
      n++;
      if (n == 1)
      begin
        chk("addr", 64'(a), 64'(addr_out));
        chk("sel", 64'(exp_sel(a)), 64'(bank_sel_n));
        chk("stb", 64'(es), 64'(stb_out));
        chk("doe", 64'(!we), 64'(data_oe_n));
        chk("stb_oe", 64'h0, 64'({stb_oe_n, stb_oe_x}));
      end
    end
    chk("done", 64'(1), 64'(core_done));
    chk("waits", 64'(1), 64'(n >= wt + 4));
    chk("stb_end", 64'hf, 64'(stb_out));
    chk("sel_end", 64'(sy ? 4'hf : exp_sel(a)), 64'(bank_sel_n));
    if (!we && (lo || hi))
      chk("rdata", shadow[key] & m, core_rdata & m);
    if (we && lo)
      shadow[{a[13:12], a[1:0]}][31:0] = wd[31:0];
    if (we && hi)
      shadow[{a[13:12], a[1:0]}][63:32] = wd[63:32];
    core_req = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : access
  task final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // main sequence: reset, corners, random, slave, suspend
  initial
  begin
    seed = 32'hf29d6b76;
    bsz = 4'h0;
    {errors, n_checks, cycles} = '0;
    {rst, core_req, core_write, core_low, core_high, core_sync} = 6'h20;
    {bus_master, suspend_n, tb_stb, wt} = {2'b11, 4'hf, 8'h0};
    {core_addr, slv_addr, core_wdata, slv_data, slave_rdata} = '0;
    for (int i = 0; i < 16; i++)
      shadow[i] = 64'h0;
    repeat (2) @(negedge clk_sys);
    chk("oe_rst", 64'hf, 64'({addr_oe_n, data_oe_n, sel_oe_n, stb_oe_n}));
    chk("sel_rst", 64'hf, 64'(bank_sel_n));
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
      access(1'b1, 1'b1, 1'b1, i[0],
        (i == 5) ? 32'h10 : 32'h0010_0000 + i * 4096,
        {$random(seed), $random(seed)});
    // bank size only moves between accesses, never during one
    for (int i = 0; i < 30; i++)
    begin
      bsz = 4'($random(seed) & 3);
      access(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
        1'($random(seed)), 32'h0010_0000 + ($random(seed) & 32'h3fff),
        {$random(seed), $random(seed)});
    end
    bus_master = 1'b0;
    core_req = 1'b1;
    // strobe drivers release one edge after mastership goes
    repeat (2) @(negedge clk_sys);
    for (int k = 0; k < 4; k++)
    begin
      slv_addr = $random(seed);
      slv_data = {$random(seed), $random(seed)};
      slave_rdata = {$random(seed), $random(seed)};
      tb_stb = ~(4'h1 << k);
      repeat (3) @(negedge clk_sys);
      chk("event", 64'(4'h1 << k), 64'(slave_ev));
      chk("saddr", 64'(slv_addr), 64'(slave_addr));
      if (k > 1)
        chk("swdata", slv_data, slave_wdata);
      @(negedge clk_sys);
      if (k < 2)
        chk("sdata", slave_rdata, data_oe_n ? 64'hx : data_out);
      chk("soe", 64'h7, 64'({addr_oe_n, sel_oe_n, stb_oe_n}));
      chk("stb_oe", 64'h7, 64'(stb_oe_x));
      chk("sdone", 64'(0), 64'(core_done));
      tb_stb = 4'hf;
      repeat (3) @(negedge clk_sys);
    end
    core_req = 1'b0;
    bus_master = 1'b1;
    suspend_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    core_req = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk("susp_oe", 64'hf, 64'({addr_oe_n, data_oe_n, sel_oe_n, stb_oe_n}));
    chk("susp_done", 64'(0), 64'(core_done));
    core_req = 1'b0;
    suspend_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    access(1'b0, 1'b1, 1'b1, 1'b0, 32'h0010_0000, 64'h0);
    final_report();
  end
endmodule : tb_external_bus_select_strobe_port
